// >>> rtl/ptc_timer_pair.sv
// one timer pair: two 16-bit timers or one 32-bit timer, wishbone regs
// assumes idle is a synchronous level; pins and clock sources are sampled
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module ptc_timer_pair
(
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      wb_cyc,
  input  wire logic                      wb_stb,
  input  wire logic                      wb_we,
  input  wire logic [ptc_pkg::ADR_W-1:0] wb_adr,
  input  wire logic [3:0]                wb_sel,
  input  wire logic [31:0]               wb_dat_w,
  output logic      [31:0]               wb_dat_r,
  output logic                           wb_ack,
  input  wire logic                      idle_mode,
  input  wire logic                      generic_timer_clock_pin,
  input  wire logic                      low_power_rc_oscillator,
  input  wire logic                      lower_timer_clock_pin,
  input  wire logic                      secondary_oscillator,
  input  wire logic                      upper_timer_clock_pin,
  output logic                           irq,
  output logic                           converter_trigger
);
  import ptc_pkg::*;

  ptc_state_t st_ff;
  ptc_state_t nxt_st;
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] fall;
  logic [15:0] ce_hi;
  logic pair;
  logic run_lo;
  logic run_hi;
  logic gated_lo;
  logic gated_hi;
  logic in_lo;
  logic in_hi;
  logic tk_lo;
  logic tk_hi;
  logic hi_evt;
  logic req;
  logic wr;
  logic [1:0] set;

  function automatic logic pick_src(input logic [15:0] c,
                                    input logic [NSRC-1:0] e,
                                    input logic own);
    case (c[ECS_H:ECS_L])
      ECS_GEN:  pick_src = e[S_GEN];
      ECS_LOW_POWER_RC_OSCILLATOR: pick_src = e[S_LOW_POWER_RC_OSCILLATOR];
      ECS_PIN:  pick_src = own;
      default:  pick_src = e[S_SECONDARY_OSCILLATOR];
    endcase
  endfunction

  // returns {tick, next prescale count}
  function automatic logic [8:0] pre_step(input logic [15:0] c,
                                          input logic [7:0] p,
                                          input logic inc);
    logic [7:0] term;
    case (c[PS_H:PS_L])
      2'h3:    term = PS_T256;
      2'h2:    term = PS_T64;
      2'h1:    term = PS_T8;
      default: term = PS_T1;
    endcase
    if (!inc)
      pre_step = {1'b0, p};
    else if (p >= term)
      pre_step = {1'b1, 8'h00};
    else
      pre_step = {1'b0, p + 8'h01};
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.trig = 1'b0;
    // three stages: first flop only feeds the second
    nxt_st.s1 = {upper_timer_clock_pin, secondary_oscillator,
                 lower_timer_clock_pin, low_power_rc_oscillator,
                 generic_timer_clock_pin};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.half = ~st_ff.half;
    rise = st_ff.s2 & ~st_ff.s3;
    fall = ~st_ff.s2 & st_ff.s3;
    pair = st_ff.ctl_lo[B_PAIR];
    ce_hi = pair ? st_ff.ctl_lo : st_ff.ctl_hi;
    run_lo = st_ff.ctl_lo[B_ON] &
             ~(st_ff.ctl_lo[B_SIDL] & idle_mode);
    run_hi = ce_hi[B_ON] & ~(ce_hi[B_SIDL] & idle_mode);
    gated_lo = ~st_ff.ctl_lo[B_CS] & st_ff.ctl_lo[B_GATE];
    gated_hi = ~ce_hi[B_CS] & ce_hi[B_GATE];
    // internal source is the system clock halved
    in_lo = st_ff.ctl_lo[B_CS] ?
            pick_src(st_ff.ctl_lo, rise, rise[S_LOP]) :
            st_ff.half & (~gated_lo | st_ff.s2[S_LOP]);
    in_hi = ce_hi[B_CS] ?
            pick_src(ce_hi, rise, rise[S_HIP]) :
            st_ff.half & (~gated_hi | st_ff.s2[S_HIP]);
    {tk_lo, nxt_st.pre_lo} = pre_step(st_ff.ctl_lo, st_ff.pre_lo,
                                      run_lo & in_lo);
    // upper prescaler frozen while paired; lower drives the pair
    {tk_hi, nxt_st.pre_hi} = pre_step(ce_hi, st_ff.pre_hi,
                                      run_hi & in_hi & ~pair);
    set = 2'b00;
    hi_evt = 1'b0;
    if (pair)
    begin
      if (tk_lo)
      begin
        if ({st_ff.cnt_hi, st_ff.cnt_lo} ==
            {st_ff.per_hi, st_ff.per_lo})
        begin
          {nxt_st.cnt_hi, nxt_st.cnt_lo} = {CNT_RST, CNT_RST};
          hi_evt = 1'b1;
        end
        else
        begin
          {nxt_st.cnt_hi, nxt_st.cnt_lo} =
            {st_ff.cnt_hi, st_ff.cnt_lo} + 32'h0000_0001;
        end
      end
      set[ST_HI] = hi_evt |
                   (run_lo & gated_lo & fall[S_LOP]);
    end
    else
    begin
      if (tk_lo)
      begin
        if (st_ff.cnt_lo == st_ff.per_lo)
        begin
          nxt_st.cnt_lo = CNT_RST;
          set[ST_LO] = 1'b1;
        end
        else
          nxt_st.cnt_lo = st_ff.cnt_lo + 16'h0001;
      end
      if (tk_hi)
      begin
        if (st_ff.cnt_hi == st_ff.per_hi)
        begin
          nxt_st.cnt_hi = CNT_RST;
          hi_evt = 1'b1;
        end
        else
          nxt_st.cnt_hi = st_ff.cnt_hi + 16'h0001;
      end
      set[ST_LO] = set[ST_LO] |
                   (run_lo & gated_lo & fall[S_LOP]);
      set[ST_HI] = hi_evt | (run_hi & gated_hi & fall[S_HIP]);
    end
    nxt_st.trig = hi_evt;
    // bus: one wait state, every address answered
    req = wb_cyc & wb_stb & ~st_ff.ack;
    wr = req & wb_we;
    nxt_st.ack = req;
    case (wb_adr)
      ADR_CTL_LO: nxt_st.dat = {16'h0000, st_ff.ctl_lo};
      ADR_CTL_HI: nxt_st.dat = {16'h0000, st_ff.ctl_hi};
      ADR_CNT_LO: nxt_st.dat = {16'h0000, st_ff.cnt_lo};
      ADR_CNT_HI: nxt_st.dat = {16'h0000, st_ff.cnt_hi};
      ADR_PER_LO: nxt_st.dat = {16'h0000, st_ff.per_lo};
      ADR_PER_HI: nxt_st.dat = {16'h0000, st_ff.per_hi};
      ADR_STS:    nxt_st.dat = {30'h0, st_ff.sts};
      ADR_MSK:    nxt_st.dat = {30'h0, st_ff.msk};
      default:    nxt_st.dat = 32'h0000_0000;
    endcase
    if (!req || wb_we)
      nxt_st.dat = st_ff.dat;
    nxt_st.sts = st_ff.sts | set;
    if (wr)
    begin
      case (wb_adr)
        ADR_CTL_LO:
        begin
          nxt_st.ctl_lo = wmerge(st_ff.ctl_lo, wb_dat_w, wb_sel) &
                          CTL_LO_MASK;
          if (st_ff.ctl_lo[B_ON])
            nxt_st.pre_lo = 8'h00;
        end
        ADR_CTL_HI:
        begin
          nxt_st.ctl_hi = wmerge(st_ff.ctl_hi, wb_dat_w, wb_sel) &
                          CTL_HI_MASK;
          if (st_ff.ctl_hi[B_ON])
            nxt_st.pre_hi = 8'h00;
        end
        ADR_CNT_LO: nxt_st.cnt_lo = wmerge(st_ff.cnt_lo, wb_dat_w, wb_sel);
        ADR_CNT_HI: nxt_st.cnt_hi = wmerge(st_ff.cnt_hi, wb_dat_w, wb_sel);
        ADR_PER_LO: nxt_st.per_lo = wmerge(st_ff.per_lo, wb_dat_w, wb_sel);
        ADR_PER_HI: nxt_st.per_hi = wmerge(st_ff.per_hi, wb_dat_w, wb_sel);
        // write one clears; a same-cycle event still sets
        ADR_STS: nxt_st.sts = (st_ff.sts & ~(wb_sel[0] ? wb_dat_w[1:0] :
                               2'b00)) | set;
        ADR_MSK: nxt_st.msk = wb_sel[0] ? wb_dat_w[1:0] : st_ff.msk;
        default: nxt_st.msk = st_ff.msk;
      endcase
    end
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.per_lo <= PER_RST;
      st_ff.per_hi <= PER_RST;
      st_ff.ctl_lo <= CTL_RST;
      st_ff.ctl_hi <= CTL_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign wb_dat_r = st_ff.dat;
  assign wb_ack = st_ff.ack;
  assign irq = st_ff.irq;
  assign converter_trigger = st_ff.trig;

  sequence s_bus_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence

  a_bus_ack_once: assert property (@(posedge clock) disable iff (rst)
    s_bus_req |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single cycle after request");

  a_ctl_unused_zero: assert property (
    @(posedge clock) disable iff (rst)
    ((st_ff.ctl_lo & ~CTL_LO_MASK) == 16'h0000) &&
    ((st_ff.ctl_hi & ~CTL_HI_MASK) == 16'h0000))
    else $error("unimplemented control bit set");

  a_pre_clear_write: assert property (
    @(posedge clock) disable iff (rst)
    (wr && wb_adr == ADR_CTL_LO && st_ff.ctl_lo[B_ON]) |=>
    st_ff.pre_lo == 8'h00)
    else $error("prescaler not cleared by control write");

  a_lo_stopped_hold: assert property (
    @(posedge clock) disable iff (rst)
    (!st_ff.ctl_lo[B_ON] && !wr) |=> $stable(st_ff.cnt_lo))
    else $error("lower count moved while disabled");

  a_idle_halt_hold: assert property (
    @(posedge clock) disable iff (rst)
    (idle_mode && st_ff.ctl_lo[B_SIDL] && !wr) |=>
    $stable(st_ff.cnt_lo) && $stable(st_ff.pre_lo))
    else $error("lower timer ran in idle with stop set");

  a_pair_wrap_flag: assert property (
    @(posedge clock) disable iff (rst)
    (pair && tk_lo && !wr && ({st_ff.cnt_hi, st_ff.cnt_lo} ==
     {st_ff.per_hi, st_ff.per_lo})) |=>
    st_ff.cnt_lo == 16'h0000 && st_ff.cnt_hi == 16'h0000 &&
    st_ff.sts[ST_HI] && converter_trigger)
    else $error("32-bit match did not clear and flag");

  // high word may only move with a lower tick or a bus write
  a_pair_hi_frozen: assert property (
    @(posedge clock) disable iff (rst)
    (pair && !tk_lo && !wr) |=> $stable(st_ff.cnt_hi))
    else $error("upper count moved on its own in pair mode");

  a_trig_cause: assert property (
    @(posedge clock) disable iff (rst)
    converter_trigger |-> $past(hi_evt && (pair ? tk_lo : tk_hi)))
    else $error("trigger without upper or pair match");

  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    ((st_ff.sts & st_ff.msk) != 2'b00) |-> irq)
    else $error("interrupt low with unmasked flag");

endmodule // ptc_timer_pair

// >>> rtl/ptc_pkg.sv
// constants and state type for the paired timer control block
// assumes one 25 MHz clock (the system clock) and a 32-bit wishbone slave
package ptc_pkg;
  localparam int ADR_W = 6;
  localparam logic [5:0] ADR_CTL_LO = 6'h00;
  localparam logic [5:0] ADR_CTL_HI = 6'h04;
  localparam logic [5:0] ADR_CNT_LO = 6'h08;
  localparam logic [5:0] ADR_CNT_HI = 6'h0c;
  localparam logic [5:0] ADR_PER_LO = 6'h10;
  localparam logic [5:0] ADR_PER_HI = 6'h14;
  localparam logic [5:0] ADR_STS    = 6'h18;
  localparam logic [5:0] ADR_MSK    = 6'h1c;
  // control register fields
  localparam int B_ON   = 15;
  localparam int B_SIDL = 13;
  localparam int ECS_H  = 9;
  localparam int ECS_L  = 8;
  localparam int B_GATE = 6;
  localparam int PS_H   = 5;
  localparam int PS_L   = 4;
  localparam int B_PAIR = 3;
  localparam int B_PAIR2 = 3;
  localparam int B_CS   = 1;
  localparam logic [15:0] CTL_LO_MASK = 16'ha37a;
  localparam logic [15:0] CTL_HI_MASK = 16'ha372;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [1:0]  ECS_GEN  = 2'h3;
  localparam logic [1:0]  ECS_LOW_POWER_RC_OSCILLATOR = 2'h2;
  localparam logic [1:0]  ECS_PIN  = 2'h1;
  localparam logic [1:0]  ECS_SECONDARY_OSCILLATOR = 2'h0;
  // prescaler terminal counts for 1, 8, 64, 256
  localparam logic [7:0] PS_T1   = 8'h00;
  localparam logic [7:0] PS_T8   = 8'h07;
  localparam logic [7:0] PS_T64  = 8'h3f;
  localparam logic [7:0] PS_T256 = 8'hff;
  localparam int FOSC_DIV = 2;
  // synchronised input slots
  localparam int NSRC   = 5;
  localparam int S_GEN  = 0;
  localparam int S_LOW_POWER_RC_OSCILLATOR = 1;
  localparam int S_LOP  = 2;
  localparam int S_SECONDARY_OSCILLATOR = 3;
  localparam int S_HIP  = 4;
  localparam int ST_LO = 0;
  localparam int ST_HI = 1;
  typedef struct packed {
    logic [15:0] ctl_lo;
    logic [15:0] ctl_hi;
    logic [15:0] cnt_lo;
    logic [15:0] cnt_hi;
    logic [15:0] per_lo;
    logic [15:0] per_hi;
    logic [7:0]  pre_lo;
    logic [7:0]  pre_hi;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        half;
    logic [NSRC-1:0] s1;
    logic [NSRC-1:0] s2;
    logic [NSRC-1:0] s3;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
    logic        trig;
  } ptc_state_t;
endpackage

// >>> bench/ptc_src_model.sv
// far side: bursts of clock pulses on one source pin, static gate levels
// assumes go is a one-cycle strobe from the bench
`timescale 1ns/1ns
module ptc_src_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [2:0] slot,
  input  wire logic [9:0] n,
  input  wire logic [4:0] lvl,
  output logic      [4:0] pins,
  output logic            busy
);
  logic [9:0] left_ff;
  logic [1:0] tm_ff;
  logic       ph_ff;
  logic [2:0] cur_ff;
  // pins stand at the lvl levels between bursts, no free-running source
  assign pins = lvl | ({4'h0, ph_ff} << cur_ff);
  assign busy = left_ff != 10'h000;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      left_ff <= 10'h000;
      tm_ff <= 2'h0;
      ph_ff <= 1'b0;
      cur_ff <= 3'h0;
    end
    else if (go)
    begin
      left_ff <= n;
      cur_ff <= slot;
    end
    else if (busy)
    begin
      tm_ff <= tm_ff + 2'h1;
      // three cycles a level: the sync chain needs two to see it
      if (tm_ff == 2'h2)
      begin
        tm_ff <= 2'h0;
        ph_ff <= !ph_ff;
        left_ff <= left_ff - {9'h000, ph_ff};
      end
    end
  end
endmodule // ptc_src_model

// >>> bench/test_ptc_timer_pair.sv
// self-checking bench: wishbone register tasks plus pin bursts
// assumes ptc_timer_pair with one 25 MHz clock and the source model
`timescale 1ns/1ns
module test_ptc_timer_pair;
  import ptc_pkg::*;
  localparam logic [15:0] ON = 16'h8000;
  localparam logic [15:0] PR = 16'h0008;
  localparam logic [15:0] CS = 16'h0002;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [5:0]  wb_adr = 6'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        idle_mode = 1'b0;
  logic [4:0]  pins;
  logic        irq;
  logic        trg;
  logic        go = 1'b0;
  logic [2:0]  slot = 3'h0;
  logic [9:0]  n = 10'h000;
  logic [4:0]  lvl = 5'h00;
  logic        busy;
  logic [31:0] q;
  int          errors = 0;
  int          compares = 0;
  int          trigs = 0;
  int          t0;
  int          dv[4] = '{1, 8, 64, 256};
  always #20 clock = ~clock;
  always @(posedge clock)
    if (trg === 1'b1)
      trigs++;
  ptc_timer_pair dut
  (
    .clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .idle_mode(idle_mode),
    .generic_timer_clock_pin(pins[S_GEN]),
    .low_power_rc_oscillator(pins[S_LOW_POWER_RC_OSCILLATOR]),
    .lower_timer_clock_pin(pins[S_LOP]),
    .secondary_oscillator(pins[S_SECONDARY_OSCILLATOR]),
    .upper_timer_clock_pin(pins[S_HIP]),
    .irq(irq), .converter_trigger(trg)
  );
  ptc_src_model src
  (
    .clock(clock), .rst(rst), .go(go), .slot(slot), .n(n), .lvl(lvl),
    .pins(pins), .busy(busy)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [5:0] a, input logic w, input logic [15:0] d);
    int t;
    t = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= {16'h0000, d};
    @(posedge clock);
    while (wb_ack !== 1'b1 && t < 20)
    begin
      @(posedge clock);
      t++;
    end
    if (t == 20)
      errors++;
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(a, 1'b0, 16'h0000);
    check(q, e);
  endtask
  // internal counts: edge phase of the half-rate tick is not pinned down
  task automatic near(input logic [5:0] a, input logic [31:0] e);
    wb(a, 1'b0, 16'h0000);
    check((q + 3 >= e && q <= e + 3) ? e : q, e);
  endtask
  task automatic pulse(input logic [2:0] s, input logic [9:0] k);
    go <= 1'b1;
    slot <= s;
    n <= k;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy)
      @(posedge clock);
    repeat (8) @(posedge clock);
  endtask
  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ADR_CTL_LO, 0);
    rd(ADR_PER_HI, 32'hffff);
    rd(6'h20, 0);
    wr(ADR_CTL_HI, 16'hffff);
    rd(ADR_CTL_HI, 32'ha372);
    wr(ADR_CTL_HI, 0);
    wr(ADR_CTL_LO, 16'hffff);
    rd(ADR_CTL_LO, 32'ha37a);
    for (int e = 0; e < 4; e++)
    begin
      wr(ADR_CNT_LO, 0);
      wr(ADR_CTL_LO, ON | CS | 16'(e << 8));
      pulse(3'((4 - e) % 4), 3);
      pulse(3'(3 - e), 5);
      rd(ADR_CNT_LO, 5);
    end
    wr(ADR_CTL_LO, 0);
    wr(ADR_CNT_LO, 0);
    idle_mode <= 1'b1;
    wr(ADR_CTL_LO, ON | 16'h2000);
    repeat (40) @(posedge clock);
    rd(ADR_CNT_LO, 0);
    wr(ADR_CTL_LO, ON | 16'h0300);
    pulse(S_GEN, 2);
    repeat (78) @(posedge clock);
    wr(ADR_CTL_LO, 0);
    idle_mode <= 1'b0;
    near(ADR_CNT_LO, 50);
    for (int p = 0; p < 4; p++)
    begin
      wr(ADR_CNT_LO, 0);
      wr(ADR_CTL_LO, ON | CS | 16'h0300 | 16'(p << 4));
      wr(ADR_CTL_LO, ON | CS | 16'h0300 | 16'(p << 4));
      pulse(S_GEN, 10'(3 * dv[p] - 1));
      rd(ADR_CNT_LO, 2);
    end
    wr(ADR_CNT_LO, 0);
    wr(ADR_CTL_LO, ON | 16'h0030);
    repeat (300) @(posedge clock);
    wr(ADR_CTL_LO, ON | 16'h0030);
    repeat (300) @(posedge clock);
    rd(ADR_CNT_LO, 0);
    wr(ADR_CTL_HI, ON | CS | 16'h0100);
    pulse(S_HIP, 4);
    rd(ADR_CNT_HI, 4);
    wr(ADR_CTL_LO, PR);
    wr(ADR_CTL_HI, ON | 16'h0030);
    wr(ADR_CNT_LO, 16'hfffe);
    wr(ADR_CNT_HI, 0);
    wr(ADR_CTL_LO, ON | PR | CS | 16'h0100);
    pulse(S_LOP, 4);
    rd(ADR_CNT_LO, 2);
    rd(ADR_CNT_HI, 1);
    wr(ADR_CTL_LO, PR);
    wr(ADR_PER_LO, 3);
    wr(ADR_PER_HI, 0);
    wr(ADR_CNT_LO, 0);
    wr(ADR_CNT_HI, 0);
    t0 = trigs;
    wr(ADR_CTL_LO, ON | PR | CS | 16'h0100);
    pulse(S_LOP, 4);
    rd(ADR_CNT_LO, 0);
    rd(ADR_STS, 2);
    check(irq, 0);
    wr(ADR_MSK, 3);
    check(irq, 1);
    check(trigs - t0, 1);
    wr(ADR_CTL_LO, 0);
    wr(ADR_STS, 2);
    rd(ADR_STS, 0);
    check(irq, 0);
    wr(ADR_PER_LO, 1);
    wr(ADR_CNT_LO, 0);
    wr(ADR_CTL_LO, ON | CS | 16'h0100);
    pulse(S_LOP, 2);
    rd(ADR_STS, 1);
    check(irq, 1);
    check(trigs - t0, 1);
    wr(ADR_CTL_LO, 0);
    wr(ADR_STS, 3);
    wr(ADR_PER_LO, 16'hffff);
    wr(ADR_CNT_LO, 0);
    wr(ADR_CTL_LO, ON | 16'h0040);
    repeat (40) @(posedge clock);
    rd(ADR_CNT_LO, 0);
    lvl <= 5'h04;
    repeat (100) @(posedge clock);
    lvl <= 5'h00;
    repeat (10) @(posedge clock);
    wr(ADR_CTL_LO, 0);
    near(ADR_CNT_LO, 50);
    rd(ADR_STS, 1);
    test_done();
  end
endmodule // test_ptc_timer_pair
